// >>> hbd_cfg.svh
// Timing constants, command and level encodings for the H-bridge drive control block
`ifndef HBD_CFG_SVH
`define HBD_CFG_SVH
`define HBD_CLK_MHZ        125
`define HBD_TICK_NS        100
`define HBD_TICK_CYC       ((`HBD_TICK_NS * `HBD_CLK_MHZ + 999) / 1000)
`define HBD_DEAD_NS        200
`define HBD_DEAD_TICKS     (`HBD_DEAD_NS / `HBD_TICK_NS)
`define HBD_INDEG_NS       300
`define HBD_INDEG_TICKS    (`HBD_INDEG_NS / `HBD_TICK_NS)
`define HBD_UV_QUAL_US     10
`define HBD_UV_TICKS       (`HBD_UV_QUAL_US * 1000 / `HBD_TICK_NS)
`define HBD_OC_QUAL_NS     1500
`define HBD_OC_TICKS       (`HBD_OC_QUAL_NS / `HBD_TICK_NS)
`define HBD_OFF_US         25
`define HBD_OFF_TICKS      (`HBD_OFF_US * 1000 / `HBD_TICK_NS)
`define HBD_RETRY_MS       3
`define HBD_RETRY_TICKS    (`HBD_RETRY_MS * 1000000 / `HBD_TICK_NS)
`define HBD_SLEEP_MS       1
`define HBD_SLEEP_TICKS    (`HBD_SLEEP_MS * 1000000 / `HBD_TICK_NS)
`define HBD_CNT_W          16
`define HBD_CNT_ONE        16'h0001
`define HBD_CNT_ZERO       16'h0000
`define HBD_CMD_COAST      2'h0
`define HBD_CMD_REV        2'h1
`define HBD_CMD_FWD        2'h2
`define HBD_CMD_BRAKE      2'h3
`define HBD_LVL_Z          2'h0
`define HBD_LVL_LOW        2'h1
`define HBD_LVL_HIGH       2'h2
`endif

// >>> hbd_pkg.sv
// Types shared by the H-bridge drive control block
package hbd_pkg;
    // Drive level of one half-bridge: high side and low side gate enables
    typedef struct packed {
        logic hi_on;
        logic lo_on;
    } hbd_leg_s;
    typedef enum logic [3:0] {
        HBD_RUN   = 4'h1,
        HBD_CHOP  = 4'h2,
        HBD_FAULT = 4'h4,
        HBD_SLEEP = 4'h8
    } hbd_state_e;
endpackage

// >>> hbd_drive_ctrl.sv
// H-bridge drive control: input decode, dead time, chopping and fault sequencing
`timescale 1ns/1ps
`include "hbd_cfg.svh"
module hbd_drive_ctrl
    import hbd_pkg::*;
#(
    parameter int SLEEP_TICKS = `HBD_SLEEP_TICKS,
    parameter int RETRY_TICKS = `HBD_RETRY_TICKS,
    parameter int OFF_TICKS   = `HBD_OFF_TICKS,
    parameter int UV_TICKS    = `HBD_UV_TICKS
) (
    input  wire logic     i_sys_clk,
    input  wire logic     i_rst,
    input  wire logic     i_first_control_input,
    input  wire logic     i_second_control_input,
    input  wire logic     i_supply_low,
    input  wire logic     i_overcurrent,
    input  wire logic     i_current_over_trip,
    output hbd_leg_s      o_first_bridge_output,
    output hbd_leg_s      o_second_bridge_output,
    output logic          o_sleep,
    output logic          o_overcurrent_shutdown,
    output logic          o_supply_low_lockout
);
    localparam int CW = `HBD_CNT_W;
    localparam logic [CW-1:0] TICK_N  = CW'(`HBD_TICK_CYC);
    localparam logic [CW-1:0] INDEG_N = CW'(`HBD_INDEG_TICKS);
    localparam logic [CW-1:0] OC_N    = CW'(`HBD_OC_TICKS);
    localparam logic [CW-1:0] UV_N    = CW'(UV_TICKS);
    localparam logic [CW-1:0] OFF_N   = CW'(OFF_TICKS);
    localparam logic [CW-1:0] DEAD_N  = CW'(`HBD_DEAD_TICKS);
    localparam logic [23:0]   SLP_N   = 24'(SLEEP_TICKS);
    localparam logic [23:0]   RTY_N   = 24'(RETRY_TICKS);

    // Free-running time base, one enable pulse per tick
    logic [CW-1:0] tb_q;
    wire           tick = (tb_q == TICK_N - `HBD_CNT_ONE);
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || tick) tb_q <= `HBD_CNT_ZERO;
        else tb_q <= tb_q + `HBD_CNT_ONE;
    end

    // Undervoltage qualification; qualified low supply resets everything else but the time base
    logic [CW-1:0] uv_cnt_q;
    logic          uv_q;
    always_ff @(posedge i_sys_clk) begin
        if (i_rst || !i_supply_low) begin
            uv_cnt_q <= `HBD_CNT_ZERO;
            uv_q     <= 1'b0;
        end else if (tick && !uv_q) begin
            uv_cnt_q <= uv_cnt_q + `HBD_CNT_ONE;
            uv_q     <= (uv_cnt_q + `HBD_CNT_ONE >= UV_N);
        end
    end
    wire lrst = i_rst || uv_q;

    // Input deglitch: raw pair must hold steady for the filter time
    logic [1:0]    raw_q;
    logic [1:0]    cmd_q;
    logic [CW-1:0] dg_cnt_q;
    wire  [1:0]    raw = {i_first_control_input, i_second_control_input};
    always_ff @(posedge i_sys_clk) begin
        if (lrst) begin
            raw_q    <= `HBD_CMD_COAST;
            cmd_q    <= `HBD_CMD_COAST;
            dg_cnt_q <= `HBD_CNT_ZERO;
        end else if (raw != raw_q) begin
            raw_q    <= raw;
            dg_cnt_q <= `HBD_CNT_ZERO;
        end else if (tick && raw_q != cmd_q) begin
            dg_cnt_q <= dg_cnt_q + `HBD_CNT_ONE;
            if (dg_cnt_q + `HBD_CNT_ONE >= INDEG_N) cmd_q <= raw_q;
        end
    end
    wire cmd_chg = (raw_q == raw) && tick && (raw_q != cmd_q)
                   && (dg_cnt_q + `HBD_CNT_ONE >= INDEG_N);

    // Overcurrent qualification; held clear while the bridge is off for retry,
    // so every re-enable has to qualify the fault again
    hbd_state_e    st_q;
    logic [CW-1:0] oc_cnt_q;
    wire           oc_qual = (oc_cnt_q >= OC_N);
    wire           oc_clr  = lrst || !i_overcurrent || (st_q == HBD_FAULT);
    always_ff @(posedge i_sys_clk) begin
        if (oc_clr) oc_cnt_q <= `HBD_CNT_ZERO;
        else if (tick && !oc_qual) oc_cnt_q <= oc_cnt_q + `HBD_CNT_ONE;
    end

    // Main sequencer: run, chopping off time, fault retry, sleep
    logic [23:0]   tmr_q;
    wire           coast = (cmd_q == `HBD_CMD_COAST);
    always_ff @(posedge i_sys_clk) begin
        if (lrst) begin
            st_q  <= HBD_SLEEP;
            tmr_q <= 24'h000000;
        end else begin
            case (st_q)
                HBD_RUN: begin
                    if (oc_qual) begin
                        st_q  <= HBD_FAULT;
                        tmr_q <= 24'h000000;
                    end else if (i_current_over_trip && !coast) begin
                        st_q  <= HBD_CHOP;
                        tmr_q <= 24'h000000;
                    end else if (coast) begin
                        if (tick) tmr_q <= tmr_q + 24'h000001;
                        if (tmr_q >= SLP_N) st_q <= HBD_SLEEP;
                    end else begin
                        tmr_q <= 24'h000000;
                    end
                end
                HBD_CHOP: begin
                    if (oc_qual) begin
                        st_q  <= HBD_FAULT;
                        tmr_q <= 24'h000000;
                    end else if (cmd_chg) begin
                        st_q  <= HBD_RUN;
                        tmr_q <= 24'h000000;
                    end else if (tmr_q >= {8'h00, OFF_N}) begin
                        tmr_q <= 24'h000000;
                        if (!i_current_over_trip) st_q <= HBD_RUN;
                    end else if (tick) begin
                        tmr_q <= tmr_q + 24'h000001;
                    end
                end
                HBD_FAULT: begin
                    if (tmr_q >= RTY_N) begin
                        st_q  <= HBD_RUN;
                        tmr_q <= 24'h000000;
                    end else if (tick) begin
                        tmr_q <= tmr_q + 24'h000001;
                    end
                end
                default: begin
                    tmr_q <= 24'h000000;
                    if (!coast) st_q <= HBD_RUN;
                end
            endcase
        end
    end

    // Wanted leg levels from the command and state
    logic [1:0] want1;
    logic [1:0] want2;
    always_comb begin
        want1 = `HBD_LVL_Z;
        want2 = `HBD_LVL_Z;
        if (st_q == HBD_CHOP) begin
            want1 = `HBD_LVL_LOW;
            want2 = `HBD_LVL_LOW;
        end else if (st_q == HBD_RUN) begin
            case (cmd_q)
                `HBD_CMD_REV: begin
                    want1 = `HBD_LVL_LOW;
                    want2 = `HBD_LVL_HIGH;
                end
                `HBD_CMD_FWD: begin
                    want1 = `HBD_LVL_HIGH;
                    want2 = `HBD_LVL_LOW;
                end
                `HBD_CMD_BRAKE: begin
                    want1 = `HBD_LVL_LOW;
                    want2 = `HBD_LVL_LOW;
                end
                default: begin
                    want1 = `HBD_LVL_Z;
                    want2 = `HBD_LVL_Z;
                end
            endcase
        end
    end

    // Dead-time legs, one per output
    logic [1:0] lvl1;
    logic [1:0] lvl2;
    hbd_dead_leg #(.DEAD_N(DEAD_N)) u_leg1 (
        .i_sys_clk (i_sys_clk),
        .i_rst     (lrst),
        .i_tick    (tick),
        .i_want    (want1),
        .o_lvl     (lvl1)
    );
    hbd_dead_leg #(.DEAD_N(DEAD_N)) u_leg2 (
        .i_sys_clk (i_sys_clk),
        .i_rst     (lrst),
        .i_tick    (tick),
        .i_want    (want2),
        .o_lvl     (lvl2)
    );

    assign o_first_bridge_output  = '{hi_on: lvl1[1], lo_on: lvl1[0]};
    assign o_second_bridge_output = '{hi_on: lvl2[1], lo_on: lvl2[0]};
    assign o_sleep                = (st_q == HBD_SLEEP);
    assign o_overcurrent_shutdown = (st_q == HBD_FAULT);
    assign o_supply_low_lockout   = uv_q;

    // Checks; the legs are registered, so state effects show one clock later
    shoot_thru_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !((lvl1 ^ $past(lvl1)) == 2'h3 || (lvl2 ^ $past(lvl2)) == 2'h3))
        else $error("leg switched between high and low without dead time");
    fault_off_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_overcurrent_shutdown |=> lvl1 == `HBD_LVL_Z && lvl2 == `HBD_LVL_Z)
        else $error("bridge driven during overcurrent shutdown");
    uv_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        uv_q |=> o_sleep && lvl1 == `HBD_LVL_Z && lvl2 == `HBD_LVL_Z)
        else $error("undervoltage did not reset logic");
    chop_brake_a: assert property (@(posedge i_sys_clk) disable iff (lrst)
        st_q == HBD_CHOP |=> lvl1 != `HBD_LVL_HIGH && lvl2 != `HBD_LVL_HIGH)
        else $error("chop did not force brake");
    oc_qual_a: assert property (@(posedge i_sys_clk) disable iff (lrst)
        $rose(oc_qual) |-> $past(i_overcurrent) && $past(i_overcurrent, 150))
        else $error("overcurrent qualified without a persistent fault");
    coast_z_a: assert property (@(posedge i_sys_clk) disable iff (lrst)
        st_q == HBD_RUN && coast |=> lvl1 == `HBD_LVL_Z && lvl2 == `HBD_LVL_Z)
        else $error("coast not high impedance");
endmodule

// One half-bridge leg that holds high impedance for the dead time between levels
module hbd_dead_leg
    import hbd_pkg::*;
#(
    parameter logic [15:0] DEAD_N = 16'(`HBD_DEAD_TICKS)
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst,
    input  wire logic       i_tick,
    input  wire logic [1:0] i_want,
    output logic      [1:0] o_lvl
);
    logic [1:0]  lvl_q;
    logic [1:0]  last_q;
    logic [15:0] cnt_q;
    wire         opposite = (i_want != `HBD_LVL_Z) && (last_q != `HBD_LVL_Z)
                            && (i_want != last_q);
    // Level passes straight unless it reverses, then waits out the dead time
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            lvl_q  <= `HBD_LVL_Z;
            last_q <= `HBD_LVL_Z;
            cnt_q  <= 16'h0000;
        end else if (opposite && cnt_q < DEAD_N) begin
            lvl_q <= `HBD_LVL_Z;
            if (i_tick) cnt_q <= cnt_q + 16'h0001;
        end else begin
            lvl_q  <= i_want;
            cnt_q  <= 16'h0000;
            if (i_want != `HBD_LVL_Z) last_q <= i_want;
        end
    end
    assign o_lvl = lvl_q;
endmodule

// >>> hbd_ctrl_model.sv
// Controller model that drives the two control inputs of the bridge
`timescale 1ns/1ps
module hbd_ctrl_model (
    input  wire logic       i_sys_clk,
    input  wire logic [1:0] i_cmd,
    input  wire logic       i_mod_en,
    output logic            o_first_control_input,
    output logic            o_second_control_input
);
    logic [9:0] cnt_q  = 10'h000;
    logic       half_q = 1'b0;
    logic [1:0] pair_q = 2'h0;

    // Pair starts low and is driven even while the block is held off
    assign o_first_control_input  = pair_q[1];
    assign o_second_control_input = pair_q[0];

    // 313-clock halves keep the modulation just under 200 kHz, command alternating
    // with brake; static hold of the command when modulation is off
    always @(negedge i_sys_clk) begin
        cnt_q <= (cnt_q >= 10'h138) ? 10'h000 : cnt_q + 10'h001;
        if (cnt_q >= 10'h138) begin
            half_q <= ~half_q;
        end
        pair_q <= (i_mod_en && half_q) ? 2'h3 : i_cmd;
    end
endmodule

// >>> testbench.sv
// Self-checking bench for the H-bridge drive control block
`timescale 1ns/1ps
module testbench;
    import hbd_pkg::*;
    localparam int TK = 13;
    logic       i_sys_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic       mod_en = 1'b0;
    logic [1:0] cmd = 2'h2;
    logic       sup_low = 1'b0;
    logic       oc = 1'b0;
    logic       trip = 1'b0;
    logic       in1, in2, o_sleep, o_oc, o_uv;
    hbd_leg_s   o1, o2, p1, p2;
    int         mismatches = 0;
    int         n_checks = 0;
    int         seed = 32'h4F6DD9E0;
    int         n;

    hbd_ctrl_model i_hbd_ctrl_model (.i_sys_clk(i_sys_clk), .i_cmd(cmd), .i_mod_en(mod_en),
        .o_first_control_input(in1), .o_second_control_input(in2));

    hbd_drive_ctrl #(.SLEEP_TICKS(50), .RETRY_TICKS(40), .OFF_TICKS(10), .UV_TICKS(5))
    i_hbd_drive_ctrl (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_first_control_input(in1),
        .i_second_control_input(in2), .i_supply_low(sup_low), .i_overcurrent(oc),
        .i_current_over_trip(trip), .o_first_bridge_output(o1),
        .o_second_bridge_output(o2), .o_sleep(o_sleep),
        .o_overcurrent_shutdown(o_oc), .o_supply_low_lockout(o_uv));

    always #4 i_sys_clk = ~i_sys_clk;

    task automatic check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wait_tk(input int t);
        repeat (t * TK) @(negedge i_sys_clk);
    endtask

    // Counts cycles until the shutdown flag reaches a level, bounded
    task automatic wait_oc(input logic lvl, output int k);
        k = 0;
        while (o_oc !== lvl && k < 2000) begin
            @(negedge i_sys_clk);
            k++;
        end
    endtask

    // Expected legs {first, second} for a command
    function automatic logic [3:0] drv(input logic [1:0] c);
        case (c)
            2'h1: drv = 4'h6;
            2'h2: drv = 4'h9;
            2'h3: drv = 4'h5;
            default: drv = 4'h0;
        endcase
    endfunction

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    // A leg must never jump between high and low without passing high impedance
    always @(negedge i_sys_clk) begin
        p1 <= o1;
        p2 <= o2;
        if (!i_rst && o1 !== p1) check("dead_first", {3'h0, (o1 ^ p1) == 2'h3}, 4'h0);
        if (!i_rst && o2 !== p2) check("dead_second", {3'h0, (o2 ^ p2) == 2'h3}, 4'h0);
    end

    initial begin
        #(8 * 60000);
        mismatches++;
        wrap_up();
    end

    initial begin
        repeat (10) @(negedge i_sys_clk);
        check("rst_legs", {o1, o2}, 4'h0);
        check("rst_sleep", {3'h0, o_sleep}, 4'h1);
        i_rst = 1'b0;
        // Every code first, then random commands with reversals
        for (int k = 0; k < 24; k++) begin
            cmd = (k < 4) ? 2'(k) : 2'($random(seed));
            wait_tk(12);
            check("decode", {o1, o2}, drv(cmd));
        end
        // One-tick glitches to random codes are ignored, during and after the glitch
        cmd = 2'h2;
        wait_tk(12);
        for (int k = 0; k < 4; k++) begin
            cmd = 2'($random(seed));
            wait_tk(1);
            check("deglitch_mid", {o1, o2}, drv(2'h2));
            cmd = 2'h2;
            wait_tk(6);
            check("deglitch", {o1, o2}, drv(2'h2));
        end
        // Coast, sleep entry, wake
        cmd = 2'h0;
        wait_tk(40);
        check("sleep_early", {3'h0, o_sleep}, 4'h0);
        wait_tk(30);
        check("sleep_late", {3'h0, o_sleep}, 4'h1);
        cmd = 2'h2;
        wait_tk(12);
        check("wake", {o1, o2}, drv(2'h2));
        // Chop: brake, restore, repeat while over, abort on input change
        trip = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        trip = 1'b0;
        wait_tk(4);
        check("chop_brake", {o1, o2}, 4'h5);
        wait_tk(12);
        check("chop_end", {o1, o2}, drv(2'h2));
        trip = 1'b1;
        wait_tk(16);
        check("chop_again", {o1, o2}, 4'h5);
        trip = 1'b0;
        wait_tk(14);
        trip = 1'b1;
        repeat (2) @(negedge i_sys_clk);
        trip = 1'b0;
        wait_tk(1);
        cmd = 2'h1;
        wait_tk(8);
        check("chop_abort", {o1, o2}, drv(2'h1));
        // Overcurrent: short pulse ignored, then shutdown and retries
        oc = 1'b1;
        wait_tk(10);
        oc = 1'b0;
        wait_tk(2);
        check("oc_short", {3'h0, o_oc}, 4'h0);
        oc = 1'b1;
        wait_oc(1'b1, n);
        check("oc_qual", {3'h0, n >= 14 * TK && n <= 17 * TK}, 4'h1);
        wait_tk(30);
        check("oc_hold", {o_oc, o1 | o2, 1'b0}, 4'h8);
        wait_oc(1'b0, n);
        check("oc_retry", {3'h0, n <= 12 * TK}, 4'h1);
        wait_oc(1'b1, n);
        check("oc_repeat", {3'h0, n >= 14 * TK && n <= 17 * TK}, 4'h1);
        oc = 1'b0;
        wait_tk(45);
        check("oc_resume", {o1, o2}, drv(2'h1));
        // Undervoltage: short dip ignored, long one locks out and resets
        sup_low = 1'b1;
        wait_tk(3);
        sup_low = 1'b0;
        wait_tk(2);
        check("uv_short", {3'h0, o_uv}, 4'h0);
        sup_low = 1'b1;
        wait_tk(8);
        check("uv_lock", {o_uv, o_sleep, o1 | o2}, 4'hC);
        sup_low = 1'b0;
        wait_tk(12);
        check("uv_resume", {o_uv, 3'h0}, 4'h0);
        check("uv_legs", {o1, o2}, drv(2'h1));
        // Modulated drive with brake phases; watch for shoot-through
        cmd = 2'h2;
        mod_en = 1'b1;
        repeat (6000) @(negedge i_sys_clk);
        // Coast briefly left for brake to sample current; short coasts never sleep
        cmd = 2'h0;
        repeat (2000) @(negedge i_sys_clk);
        check("sleep_mod", {3'h0, o_sleep}, 4'h0);
        wrap_up();
    end
endmodule
